// File: rtl/pin_mux_pkg.sv
// Constants, register map and pin layout for the port pin function block
package pin_mux_pkg;
    localparam int NPORT    = 11;
    localparam int NPIN     = 55;
    localparam int DW       = 8;
    localparam int AW       = 8;
    localparam int SYNC_LEN = 3;

    // Port slots, in register index order
    localparam int PORT2  = 2;
    localparam int PORT4  = 4;
    localparam int PORT5  = 5;
    localparam int PORT6  = 6;
    localparam int PORT7  = 7;
    localparam int PORT12 = 8;
    localparam int PORT13 = 9;
    localparam int PORT14 = 10;

    // Address is {kind, slot}
    localparam logic [3:0] KIND_LATCH = 4'h0;
    localparam logic [3:0] KIND_DIR   = 4'h1;
    localparam logic [3:0] KIND_PU    = 4'h2;
    localparam logic [3:0] KIND_ALT   = 4'h3;
    localparam logic [3:0] KIND_PIN   = 4'h4;
    localparam logic [3:0] KIND_CTRL  = 4'h8;

    localparam logic [3:0] CTRL_ANALOG   = 4'h0;
    localparam logic [3:0] CTRL_RISE     = 4'h1;
    localparam logic [3:0] CTRL_FALL     = 4'h2;
    localparam logic [3:0] CTRL_EXT_STAT = 4'h3;
    localparam logic [3:0] CTRL_EXT_MASK = 4'h4;
    localparam logic [3:0] CTRL_KEY_EN   = 4'h5;
    localparam logic [3:0] CTRL_KEY_STAT = 4'h6;
    localparam logic [3:0] CTRL_KEY_MASK = 4'h7;

    localparam logic [7:0]      DIR_RST    = 8'hff;
    localparam logic [7:0]      ANALOG_RST = 8'hff;
    localparam logic [NPIN-1:0] OE_RST     = 55'h10000000000000;

    function automatic int port_width(input int p);
        case (p)
            0:          return 7;
            1, 2, 7:    return 8;
            3, 4, 5, 6: return 4;
            8:          return 5;
            9:          return 1;
            10:         return 2;
            default:    return 0;
        endcase
    endfunction

    function automatic int port_base(input int p);
        case (p)
            0:       return 0;
            1:       return 7;
            2:       return 15;
            3:       return 23;
            4:       return 27;
            5:       return 31;
            6:       return 35;
            7:       return 39;
            8:       return 47;
            9:       return 52;
            10:      return 53;
            default: return 0;
        endcase
    endfunction

    function automatic logic [7:0] width_mask(input int p);
        logic [8:0] m;
        m = (9'h001 << port_width(p)) - 9'h001;
        return m[7:0];
    endfunction

    function automatic logic [7:0] pullup_mask(input int p);
        case (p)
            PORT2, PORT6, PORT13: return 8'h00;
            PORT12:               return 8'h01;
            default:              return width_mask(p);
        endcase
    endfunction

    function automatic logic [7:0] alt_mask(input int p);
        case (p)
            PORT2, PORT4, PORT5, PORT13: return 8'h00;
            default:                     return width_mask(p);
        endcase
    endfunction

    // Flat pin number of each external interrupt input
    function automatic int intp_pin(input int i);
        case (i)
            0:       return 47;
            1:       return 23;
            2:       return 24;
            3:       return 25;
            4:       return 26;
            5:       return 13;
            6:       return 53;
            default: return 54;
        endcase
    endfunction
endpackage

// File: rtl/port_pin_function_mux.sv
// Port pin latches, direction, pull-ups, alternate functions and pin interrupts
// Behaviour
// [R1] Port 0 has seven pins with per-bit direction and pull-up, all inputs after reset.
// [R2] Port 1 has eight pins with per-bit direction and pull-up, all inputs after reset.
// [R3] Port 2 has eight pins with per-bit direction, no pull-up, in analog mode after reset.
// [R4] Port 3 has four pins with per-bit direction and pull-up, all inputs after reset.
// [R5] Port 4 has four pins with direction and pull-up, inputs after reset, no alternate use.
// [R6] Port 5 has four pins with direction and pull-up, inputs after reset, no alternate use.
// [R7] Port 6 has four open-drain pins that only pull low, per-bit direction, inputs at reset.
// [R8] Port 7 has eight pins with direction and pull-up, inputs at reset, doubling as key inputs.
// [R9] Port 12 has five pins with per-bit direction, inputs at reset, pull-up on the lowest only.
// [R10] Port 13 is one output-only pin that drives from reset on and has no input path.
// [R11] Port 14 has two pins with direction and pull-up, inputs at reset, shared with outputs.
// [R12] Each of eight external interrupt inputs detects rising, falling or both edges.
// [R13] A clock fed to the serial external clock pin must run at the fixed 6.4 MHz.
// [R14] In port mode the direction bit sets each pin's direction and the pull-up bit its pull-up.
// [R15] A pin assigned to its alternate function is driven and received by the peripheral.
//
// Decided for this implementation: the placing of the registers and the strobed register port.
`timescale 1ns/100ps
`default_nettype none
module port_pin_function_mux (
    input  wire logic                          mclk_i,
    input  wire logic                          rst_b_i,
    input  wire logic [pin_mux_pkg::AW-1:0]    addr_i,
    input  wire logic [pin_mux_pkg::DW-1:0]    wdata_i,
    input  wire logic                          wr_i,
    input  wire logic                          rd_i,
    output logic      [pin_mux_pkg::DW-1:0]    rdata_o,
    input  wire logic [pin_mux_pkg::NPIN-1:0]  pad_in_i,
    output logic      [pin_mux_pkg::NPIN-1:0]  pad_out_o,
    output logic      [pin_mux_pkg::NPIN-1:0]  pad_oe_o,
    output logic      [pin_mux_pkg::NPIN-1:0]  pad_pullup_o,
    output logic      [7:0]                    analog_en_o,
    input  wire logic [pin_mux_pkg::NPIN-1:0]  alt_out_i,
    input  wire logic [pin_mux_pkg::NPIN-1:0]  alt_oe_i,
    output logic      [pin_mux_pkg::NPIN-1:0]  alt_in_o,
    output logic                               irq_o
);
    import pin_mux_pkg::*;

    logic [DW-1:0]   latch_q [NPORT];
    logic [DW-1:0]   dir_q   [NPORT];
    logic [DW-1:0]   pu_q    [NPORT];
    logic [DW-1:0]   alt_q   [NPORT];
    logic [7:0]      analog_q;
    logic [7:0]      rise_en_q;
    logic [7:0]      fall_en_q;
    logic [7:0]      ext_stat;
    logic [7:0]      ext_mask;
    logic [7:0]      key_en_q;
    logic [7:0]      key_stat;
    logic [7:0]      key_mask;
    logic [NPIN-1:0] sync1;
    logic [NPIN-1:0] sync2;
    logic [NPIN-1:0] sync3;
    logic [NPIN-1:0] pin_flt;
    logic [NPIN-1:0] pin_prev;
    logic [SYNC_LEN-1:0] armed_q;
    logic [NPIN-1:0] next_out;
    logic [NPIN-1:0] next_oe;
    logic [NPIN-1:0] next_pu;
    logic [NPIN-1:0] next_alt_in;
    logic [7:0]      intp_now;
    logic [7:0]      intp_old;
    logic [7:0]      ext_hit;
    logic [7:0]      key_fall;
    logic [7:0]      key_hit;
    logic [DW-1:0]   next_rdata;
    logic [3:0]      kind;
    logic [3:0]      sel;
    logic            slot_ok;
    logic            armed;

    assign kind    = addr_i[7:4];
    assign sel     = addr_i[3:0];
    assign slot_ok = (int'(sel) < NPORT);
    assign armed   = armed_q[SYNC_LEN-1];

    function automatic logic wr_hit(input logic [3:0] k);
        return wr_i && (kind == k) && slot_ok;
    endfunction

    function automatic logic ctrl_wr(input logic [3:0] c);
        return wr_i && (kind == KIND_CTRL) && (sel == c);
    endfunction

    // Port output latches
    always_ff @(posedge mclk_i) begin
        if (!rst_b_i) begin
            for (int p = 0; p < NPORT; p++) begin
                latch_q[p] <= 8'h00;
            end
        end else if (wr_hit(KIND_LATCH)) begin
            latch_q[sel] <= wdata_i & width_mask(int'(sel));
        end
    end

    // Direction: one means input; the output-only port stays an output
    always_ff @(posedge mclk_i) begin
        if (!rst_b_i) begin
            for (int p = 0; p < NPORT; p++) begin
                dir_q[p] <= (p == PORT13) ? 8'h00 : (DIR_RST & width_mask(p)); // R1 R2 R4 R10
            end
        end else if (wr_hit(KIND_DIR) && (int'(sel) != PORT13)) begin
            dir_q[sel] <= wdata_i & width_mask(int'(sel)); // R14
        end
    end

    // Pull-up options, only where the pin has one
    always_ff @(posedge mclk_i) begin
        if (!rst_b_i) begin
            for (int p = 0; p < NPORT; p++) begin
                pu_q[p] <= 8'h00;
            end
        end else if (wr_hit(KIND_PU)) begin
            pu_q[sel] <= wdata_i & pullup_mask(int'(sel)); // R3 R9 R14
        end
    end

    // Alternate function selects
    always_ff @(posedge mclk_i) begin
        if (!rst_b_i) begin
            for (int p = 0; p < NPORT; p++) begin
                alt_q[p] <= 8'h00;
            end
        end else if (wr_hit(KIND_ALT)) begin
            alt_q[sel] <= wdata_i & alt_mask(int'(sel)); // R5 R6 R11
        end
    end

    // Control registers
    always_ff @(posedge mclk_i) begin
        if (!rst_b_i) begin
            analog_q  <= ANALOG_RST; // R3
            rise_en_q <= 8'h00;
            fall_en_q <= 8'h00;
            ext_mask  <= 8'h00;
            key_en_q  <= 8'h00;
            key_mask  <= 8'h00;
        end else begin
            if (ctrl_wr(CTRL_ANALOG)) analog_q <= wdata_i;
            if (ctrl_wr(CTRL_RISE)) rise_en_q <= wdata_i;
            if (ctrl_wr(CTRL_FALL)) fall_en_q <= wdata_i;
            if (ctrl_wr(CTRL_EXT_MASK)) ext_mask <= wdata_i;
            if (ctrl_wr(CTRL_KEY_EN)) key_en_q <= wdata_i;
            if (ctrl_wr(CTRL_KEY_MASK)) key_mask <= wdata_i;
        end
    end

    // Pin synchronisers; a level is taken once stages two and three agree
    always_ff @(posedge mclk_i) begin
        if (!rst_b_i) begin
            sync1    <= '0;
            sync2    <= '0;
            sync3    <= '0;
            pin_flt  <= '0;
            pin_prev <= '0;
            armed_q  <= '0;
        end else begin
            sync1    <= pad_in_i;
            sync2    <= sync1;
            sync3    <= sync2;
            pin_flt  <= (sync2 & ~(sync2 ^ sync3)) | (pin_flt & (sync2 ^ sync3));
            pin_prev <= pin_flt;
            armed_q  <= {armed_q[SYNC_LEN-2:0], 1'b1};
        end
    end

    // Edge detection, held off for the first three cycles after reset; the filter holds real pin levels only from the fifth
    always_comb begin
        intp_now = 8'h00;
        intp_old = 8'h00;
        for (int i = 0; i < 8; i++) begin
            intp_now[i] = pin_flt[intp_pin(i)];
            intp_old[i] = pin_prev[intp_pin(i)];
        end
    end

    assign ext_hit  = {8{armed}} & ((intp_now & ~intp_old & rise_en_q) |
                                    (~intp_now & intp_old & fall_en_q)); // R12
    assign key_fall = {8{armed}} & ~pin_flt[46:39] & pin_prev[46:39];
    assign key_hit  = key_fall & key_en_q; // R8

    // Sticky status, write one to clear; a new event wins over the clear
    always_ff @(posedge mclk_i) begin
        if (!rst_b_i) begin
            ext_stat <= 8'h00;
            key_stat <= 8'h00;
        end else begin
            ext_stat <= (ext_stat & ~(ctrl_wr(CTRL_EXT_STAT) ? wdata_i : 8'h00)) | ext_hit; // R12
            key_stat <= (key_stat & ~(ctrl_wr(CTRL_KEY_STAT) ? wdata_i : 8'h00)) | key_hit; // R8
        end
    end

    always_ff @(posedge mclk_i) begin
        if (!rst_b_i) begin
            irq_o <= 1'b0;
        end else begin
            irq_o <= |((ext_stat & ext_mask) | (key_stat & key_mask));
        end
    end

    // Pin drive, enable and pull-up per port kind
    always_comb begin
        int i;
        i           = 0;
        next_out    = '0;
        next_oe     = '0;
        next_pu     = '0;
        next_alt_in = '0;
        for (int p = 0; p < NPORT; p++) begin
            for (int b = 0; b < port_width(p); b++) begin
                i = port_base(p) + b;
                next_pu[i]     = pu_q[p][b] & dir_q[p][b]; // R14
                next_alt_in[i] = pin_flt[i] & alt_q[p][b]; // R15
                if (p == PORT2) begin
                    next_out[i] = latch_q[p][b];
                    next_oe[i]  = ~analog_q[b] & ~dir_q[p][b]; // R3
                end else if (p == PORT6) begin
                    next_out[i] = 1'b0; // R7
                    next_oe[i]  = alt_q[p][b] ? (alt_oe_i[i] & ~alt_out_i[i])
                                              : (~dir_q[p][b] & ~latch_q[p][b]); // R7
                end else if (p == PORT13) begin
                    next_out[i] = latch_q[p][b];
                    next_oe[i]  = 1'b1; // R10
                end else if (alt_q[p][b]) begin
                    next_out[i] = alt_out_i[i]; // R15
                    next_oe[i]  = alt_oe_i[i]; // R15
                end else begin
                    next_out[i] = latch_q[p][b];
                    next_oe[i]  = ~dir_q[p][b]; // R14
                end
            end
        end
    end
    always_ff @(posedge mclk_i) begin
        if (!rst_b_i) begin
            pad_out_o    <= '0;
            pad_oe_o     <= OE_RST; // R10
            pad_pullup_o <= '0;
            alt_in_o     <= '0;
            analog_en_o  <= ANALOG_RST; // R3
        end else begin
            pad_out_o    <= next_out;
            pad_oe_o     <= next_oe;
            pad_pullup_o <= next_pu;
            alt_in_o     <= next_alt_in;
            analog_en_o  <= analog_q;
        end
    end
    // Read mux; pin reads give the pin in input mode and the latch in output mode, zero on port 2 pins in analog mode
    always_comb begin
        next_rdata = 8'h00;
        if (kind == KIND_CTRL) begin
            case (sel)
                CTRL_ANALOG:   next_rdata = analog_q;
                CTRL_RISE:     next_rdata = rise_en_q;
                CTRL_FALL:     next_rdata = fall_en_q;
                CTRL_EXT_STAT: next_rdata = ext_stat;
                CTRL_EXT_MASK: next_rdata = ext_mask;
                CTRL_KEY_EN:   next_rdata = key_en_q;
                CTRL_KEY_STAT: next_rdata = key_stat;
                CTRL_KEY_MASK: next_rdata = key_mask;
                default:       next_rdata = 8'h00;
            endcase
        end else if (slot_ok) begin
            case (kind)
                KIND_LATCH: next_rdata = latch_q[sel];
                KIND_DIR:   next_rdata = dir_q[sel];
                KIND_PU:    next_rdata = pu_q[sel];
                KIND_ALT:   next_rdata = alt_q[sel];
                KIND_PIN: begin
                    for (int b = 0; b < 8; b++) begin
                        if (int'(sel) == PORT13) begin
                            next_rdata[b] = latch_q[sel][b]; // R10
                        end else if (int'(sel) == PORT2 && analog_q[b]) begin
                            next_rdata[b] = 1'b0; // R3
                        end else begin
                            next_rdata[b] = dir_q[sel][b] ? pin_flt[port_base(int'(sel)) + b]
                                                          : latch_q[sel][b];
                        end
                    end
                    next_rdata = next_rdata & width_mask(int'(sel));
                end
                default:    next_rdata = 8'h00;
            endcase
        end
    end
    always_ff @(posedge mclk_i) begin
        if (!rst_b_i) begin
            rdata_o <= 8'h00;
        end else begin
            rdata_o <= rd_i ? next_rdata : 8'h00;
        end
    end
    // Checks
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!rst_b_i);
    sequence s_release;
        $rose(rst_b_i);
    endsequence
    sequence s_ext_event;
        ext_hit != 8'h00;
    endsequence
    sequence s_key_event;
        key_hit != 8'h00;
    endsequence
    chk_p0_reset_input: assert property (s_release |-> (pad_oe_o[6:0] == 7'h00) [*2]) // R1
        else $error("port 0 drives after reset");
    chk_p1_reset_input: assert property (s_release |-> pad_oe_o[14:7] == 8'h00 && pad_pullup_o[14:7] == 8'h00) // R2
        else $error("port 1 not input after reset");
    chk_p2_analog_reset: assert property (s_release |-> analog_en_o == 8'hff ##1 pad_oe_o[22:15] == 8'h00) // R3
        else $error("port 2 not analog after reset");
    chk_p3_reset_input: assert property (s_release |-> (pad_oe_o[26:23] == 4'h0) [*2]) // R4
        else $error("port 3 drives after reset");
    chk_p4_no_alt: assert property (##1 pad_oe_o[30:27] == ~$past(dir_q[PORT4][3:0])) // R5
        else $error("port 4 enable not from direction");
    chk_p5_no_alt: assert property (##1 pad_oe_o[34:31] == ~$past(dir_q[PORT5][3:0])) // R6
        else $error("port 5 enable not from direction");
    chk_p6_open_drain: assert property (pad_out_o[38:35] == 4'h0) // R7
        else $error("open-drain pin driven high");
    chk_key_sticky: assert property (s_key_event |=> (key_stat & $past(key_hit)) == $past(key_hit)) // R8
        else $error("key event lost");
    chk_p12_pullup_low: assert property (pad_pullup_o[51:48] == 4'h0) // R9
        else $error("port 12 upper pull-up on");
    chk_p13_output_only: assert property (pad_oe_o[52]) // R10
        else $error("output-only pin released");
    chk_p14_reset_input: assert property (s_release |-> (pad_oe_o[54:53] == 2'b00) [*2]) // R11
        else $error("port 14 drives after reset");
    chk_ext_edge_sticky: assert property (s_ext_event |=> (ext_stat & $past(ext_hit)) == $past(ext_hit)) // R12
        else $error("external edge lost");
    chk_p1_dir_drive: assert property (alt_q[1] == 8'h00 |=> pad_oe_o[14:7] == ~$past(dir_q[1])) // R14
        else $error("port 1 enable not from direction");
    chk_alt_takeover: assert property (alt_q[1][0] |=> pad_out_o[7] == $past(alt_out_i[7])) // R15
        else $error("peripheral does not drive its pin");
    chk_irq_level: assert property ((ext_stat & ext_mask) != 8'h00 |=> irq_o) // R12
        else $error("interrupt output missing");
endmodule
`default_nettype wire

// File: tb/board_pins.sv
// Board-side model of the circuitry wired to the port pins
`timescale 1ns/100ps
`default_nettype none
module board_pins (
    input  wire logic                         mclk_i,
    input  wire logic [pin_mux_pkg::NPIN-1:0] pad_out_i,
    input  wire logic [pin_mux_pkg::NPIN-1:0] pad_oe_i,
    input  wire logic [pin_mux_pkg::NPIN-1:0] pad_pullup_i,
    input  wire logic [pin_mux_pkg::NPIN-1:0] ext_val_i,
    input  wire logic [pin_mux_pkg::NPIN-1:0] ext_en_i,
    output logic      [pin_mux_pkg::NPIN-1:0] pad_level_o
);
    import pin_mux_pkg::*;
    logic [NPIN-1:0] drift = '0;
    // A floating line shows a pattern that changes every cycle
    always @(posedge mclk_i) drift <= ~drift;
    // The serial clock input pin carries no clock here; a source would run at 6.4 MHz
    always_comb begin
        for (int p = 0; p < NPIN; p++) begin
            if (pad_oe_i[p])
                pad_level_o[p] = (p >= 35 && p <= 38) ? 1'b0 : pad_out_i[p];
            else if (ext_en_i[p])
                pad_level_o[p] = ext_val_i[p];
            else if (pad_pullup_i[p] || (p >= 35 && p <= 38))
                pad_level_o[p] = 1'b1;
            else
                pad_level_o[p] = drift[p];
        end
    end
endmodule
`default_nettype wire

// File: tb/port_pin_function_mux_tb.sv
// Self-checking bench for the port pin function block
`timescale 1ns/100ps
`default_nettype none
module port_pin_function_mux_tb;
    import pin_mux_pkg::*;
    logic            mclk_i, rst_b_i, wr_i, rd_i, irq_o;
    logic [AW-1:0]   addr_i;
    logic [DW-1:0]   wdata_i, rdata_o, d, a;
    logic [7:0]      analog_en_o, ana, msk;
    logic [NPIN-1:0] pad_in_i, pad_out_o, pad_oe_o, pad_pullup_o;
    logic [NPIN-1:0] alt_out_i, alt_oe_i, alt_in_o, ext_val, ext_en;
    logic [31:0]     r;
    logic [1:0]      m;
    int              fails, check_count, seed, s;
    int              wid [11] = '{7, 8, 8, 4, 4, 4, 4, 8, 5, 1, 2};
    int              base [11] = '{0, 7, 15, 23, 27, 31, 35, 39, 47, 52, 53};
    int              ipin [8] = '{47, 23, 24, 25, 26, 13, 53, 54};
    logic [7:0]      lat [11], dir [11], pu [11], alt [11];

    port_pin_function_mux dut (.mclk_i, .rst_b_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o,
        .pad_in_i, .pad_out_o, .pad_oe_o, .pad_pullup_o, .analog_en_o, .alt_out_i,
        .alt_oe_i, .alt_in_o, .irq_o);
    board_pins board (.mclk_i, .pad_out_i(pad_out_o), .pad_oe_i(pad_oe_o),
        .pad_pullup_i(pad_pullup_o), .ext_val_i(ext_val), .ext_en_i(ext_en),
        .pad_level_o(pad_in_i));

    initial begin
        mclk_i = 1'b0;
        forever #50 mclk_i = ~mclk_i;
    end

    function automatic logic [7:0] wmask(int k);
        return 8'((9'h001 << wid[k]) - 9'h001);
    endfunction
    function automatic logic [7:0] pumask(int k);
        return (k == 2 || k == 6 || k == 9) ? 8'h00 : (k == 8) ? 8'h01 : wmask(k);
    endfunction
    function automatic bit altok(int k);
        return !(k == 2 || k == 4 || k == 5 || k == 9);
    endfunction
    function automatic logic [7:0] pin_exp(int k);
        logic [7:0] v;
        v = 8'h00;
        for (int b = 0; b < wid[k]; b++) begin
            if (k == 9 || !dir[k][b]) v[b] = lat[k][b];
            else if (!(k == 2 && ana[b])) v[b] = ext_val[base[k] + b];
        end
        return v;
    endfunction

    task automatic check(logic [63:0] seen, logic [63:0] exp);
        check_count++;
        if (seen !== exp) begin
            fails++;
            $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic conclude;
        if (fails == 0 && check_count > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    task automatic bus_wr(logic [7:0] ad, logic [7:0] dt);
        @(posedge mclk_i);
        wr_i <= 1'b1;
        addr_i <= ad;
        wdata_i <= dt;
        @(posedge mclk_i);
        wr_i <= 1'b0;
    endtask
    task automatic rd_chk(logic [7:0] ad, logic [7:0] exp);
        @(posedge mclk_i);
        rd_i <= 1'b1;
        addr_i <= ad;
        @(posedge mclk_i);
        rd_i <= 1'b0;
        #1 check(rdata_o, exp);
    endtask
    task automatic do_reset;
        rst_b_i <= 1'b0;
        repeat (8) @(posedge mclk_i);
        rst_b_i <= 1'b1;
        for (int k = 0; k < 11; k++) begin
            lat[k] = 8'h00;
            dir[k] = wmask(k);
            pu[k] = 8'h00;
            alt[k] = 8'h00;
        end
        ana = 8'hff;
    endtask
    task automatic check_pins;
        int p;
        logic inp, eo, ev, al;
        #1;
        for (int k = 0; k < 11; k++) begin
            for (int b = 0; b < wid[k]; b++) begin
                p = base[k] + b;
                inp = dir[k][b] | (k == 2 && ana[b]);
                al = alt[k][b];
                eo = (k == 9) ? 1'b1 : al ? alt_oe_i[p] : !inp;
                ev = al ? alt_out_i[p] : lat[k][b];
                if (k == 6) begin
                    eo = eo & !ev;
                    ev = 1'b0;
                end
                check(pad_oe_o[p], eo);
                if (eo) check(pad_out_o[p], ev);
                if (!al) check(pad_pullup_o[p], pu[k][b] & inp);
                check(alt_in_o[p], al ? (eo ? ev : ext_val[p]) : 1'b0);
            end
        end
    endtask

    initial begin
        repeat (50000) @(posedge mclk_i);
        fails++;
        conclude;
    end

    initial begin
        seed = 32'h8dd7;
        fails = 0;
        check_count = 0;
        {wr_i, rd_i, addr_i, wdata_i, alt_out_i, alt_oe_i, ext_val} = '0;
        ext_en = '1;
        rst_b_i = 1'b0;
        do_reset;
        check_pins;
        check(analog_en_o, 8'hff);
        for (int k = 0; k < 11; k++) if (k != 9) rd_chk({KIND_DIR, 4'(k)}, wmask(k));
        rd_chk(8'h5f, 8'h00);
        bus_wr(8'h9f, 8'h55);
        rd_chk(8'h9f, 8'h00);
        bus_wr({KIND_CTRL, CTRL_ANALOG}, 8'h00);
        ana = 8'h00;
        repeat (14) begin
            s = $unsigned($random(seed)) % 11;
            r = $random(seed);
            bus_wr({KIND_LATCH, 4'(s)}, r[7:0]);
            lat[s] = r[7:0] & wmask(s);
            bus_wr({KIND_DIR, 4'(s)}, r[15:8]);
            if (s != 9) dir[s] = r[15:8] & wmask(s);
            bus_wr({KIND_PU, 4'(s)}, r[23:16]);
            pu[s] = r[23:16] & pumask(s);
            ext_val <= 55'({$random(seed), $random(seed)});
            repeat (8) @(posedge mclk_i);
            check(analog_en_o, ana);
            check_pins;
            rd_chk({KIND_LATCH, 4'(s)}, lat[s]);
            if (s != 9) rd_chk({KIND_DIR, 4'(s)}, dir[s]);
            rd_chk({KIND_PU, 4'(s)}, pu[s]);
            rd_chk({KIND_PIN, 4'(s)}, pin_exp(s));
        end
        repeat (8) begin
            s = $unsigned($random(seed)) % 11;
            a = $random(seed);
            bus_wr({KIND_ALT, 4'(s)}, a);
            alt[s] = altok(s) ? a & wmask(s) : 8'h00;
            alt_out_i <= 55'({$random(seed), $random(seed)});
            alt_oe_i <= 55'({$random(seed), $random(seed)});
            repeat (8) @(posedge mclk_i);
            check_pins;
            rd_chk({KIND_ALT, 4'(s)}, alt[s]);
        end
        do_reset;
        ext_val <= '0;
        repeat (8) @(posedge mclk_i);
        for (int i = 0; i < 8; i++) begin
            m = 2'(i % 3 + 1);
            msk = (i % 2 == 0) ? 8'(1 << i) : 8'h00;
            bus_wr({KIND_CTRL, CTRL_RISE}, 8'(m[0]) << i);
            bus_wr({KIND_CTRL, CTRL_FALL}, 8'(m[1]) << i);
            bus_wr({KIND_CTRL, CTRL_EXT_MASK}, msk);
            bus_wr({KIND_CTRL, CTRL_EXT_STAT}, 8'hff);
            ext_val[ipin[i]] <= 1'b1;
            repeat (8) @(posedge mclk_i);
            rd_chk({KIND_CTRL, CTRL_EXT_STAT}, 8'(m[0]) << i);
            check(irq_o, m[0] & msk[i]);
            bus_wr({KIND_CTRL, CTRL_EXT_STAT}, 8'hff);
            rd_chk({KIND_CTRL, CTRL_EXT_STAT}, 8'h00);
            ext_val[ipin[i]] <= 1'b0;
            repeat (8) @(posedge mclk_i);
            rd_chk({KIND_CTRL, CTRL_EXT_STAT}, 8'(m[1]) << i);
            check(irq_o, m[1] & msk[i]);
            bus_wr({KIND_CTRL, CTRL_EXT_STAT}, 8'hff);
        end
        bus_wr({KIND_CTRL, CTRL_KEY_EN}, 8'h01);
        bus_wr({KIND_CTRL, CTRL_KEY_MASK}, 8'h03);
        ext_val[40:39] <= 2'b11;
        repeat (8) @(posedge mclk_i);
        bus_wr({KIND_CTRL, CTRL_KEY_STAT}, 8'hff);
        ext_val[40:39] <= 2'b00;
        repeat (8) @(posedge mclk_i);
        rd_chk({KIND_CTRL, CTRL_KEY_STAT}, 8'h01);
        check(irq_o, 1'b1);
        bus_wr({KIND_CTRL, CTRL_KEY_STAT}, 8'h01);
        repeat (2) @(posedge mclk_i);
        check(irq_o, 1'b0);
        conclude;
    end
endmodule
`default_nettype wire
